// File: ais_pkg.sv
// Package for the converter input-select register bank
package ais_pkg;
    localparam int          AIS_AW          = 12;
    // Register groups, address bits [7:4]; alias kind in bits [3:2]
    localparam logic [3:0]  AIS_GRP_TIMING  = 4'h0;
    localparam logic [3:0]  AIS_GRP_CTRL    = 4'h1;
    localparam logic [3:0]  AIS_GRP_CHS     = 4'h2;
    localparam logic [3:0]  AIS_GRP_PIN_MODE_BITS    = 4'h3;
    localparam logic [3:0]  AIS_GRP_SCAN_INCLUDE_BITS    = 4'h4;
    localparam logic [3:0]  AIS_GRP_STATUS  = 4'h5;
    localparam logic [1:0]  AIS_KIND_BASE   = 2'h0;
    localparam logic [1:0]  AIS_KIND_CLR    = 2'h1;
    localparam logic [1:0]  AIS_KIND_SET    = 2'h2;
    localparam logic [1:0]  AIS_KIND_INV    = 2'h3;
    // Byte offsets of the bases; aliases sit at +4, +8, +c
    localparam logic [11:0] AIS_OFF_TIMING  = 12'h000;
    localparam logic [11:0] AIS_OFF_CTRL    = 12'h010;
    localparam logic [11:0] AIS_OFF_CHS     = 12'h020;
    localparam logic [11:0] AIS_OFF_PIN_MODE_BITS    = 12'h030;
    localparam logic [11:0] AIS_OFF_SCAN_INCLUDE_BITS    = 12'h040;
    localparam logic [11:0] AIS_OFF_STATUS  = 12'h050;
    // Implemented bits; all others are reserved and stay zero
    localparam logic [31:0] AIS_TIMING_MASK = 32'h00009fff;
    localparam logic [31:0] AIS_CTRL_MASK   = 32'h00000401;
    localparam logic [31:0] AIS_CHS_MASK    = 32'h8f8f0000;
    localparam logic [31:0] AIS_PIN_MASK    = 32'h0000ffff;
    localparam logic [31:0] AIS_RST_VALUE   = 32'h00000000;
    // Field positions
    localparam int          AIS_CTRL_SCAN   = 10;
    localparam int          AIS_CTRL_ALTERNATE_SAMPLING_ENABLE   = 0;
    localparam int          AIS_CHS_NEG_B   = 31;
    localparam int          AIS_CHS_POS_B   = 24;
    localparam int          AIS_CHS_NEG_A   = 23;
    localparam int          AIS_CHS_POS_A   = 16;
    localparam int          AIS_CH_N        = 16;

    typedef enum logic {AIS_SEQ_IDLE, AIS_SEQ_RUN} ais_seq_e;

    typedef struct packed {
        logic [15:0] timing;
        logic        scan_en;
        logic        alternate_sampling_enable_en;
        logic [31:0] chs;
        logic [15:0] pin_mode_bits;
        logic [15:0] scan_include_bits;
        ais_seq_e    seq;
        logic        use_b;
        logic [3:0]  scan_ch;
        logic [3:0]  pos_ch;
        logic        neg_an1;
        logic        pos_gnd;
        logic [15:0] port_rd;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ais_state_s;
endpackage

// File: ais_input_select.sv
// Converter input-select register bank with mux sequencing, APB slave
// Functional notes
// - Clear alias write zeroes target bits where written word has ones.
// - Set alias write sets target bits where written word has ones.
// - Invert alias write toggles target bits where written word has ones.
// - Zeros written through any alias leave target bits unchanged.
// - Aliases never change reserved or read-only bits.
// - Alias reads return an undefined value; here zero.
// - Second-setting negative bit picks input one, else negative reference.
// - Second-setting positive field picks analog input n.
// - First-setting negative bit picks input one, else negative reference.
// - First-setting positive field picks analog input n.
// - Pin mode one: digital read enabled, mux input tied to analog ground.
// - Pin mode zero: analog, digital read returns one, converter samples pin.
// - Scan mask one includes an input in the scan, zero skips it.
// - Scan enable makes first-setting positive input come from scan mask.
// - Alternate sampling: first sample uses first setting, then alternate.
`timescale 1ns/100ps
module ais_input_select
    import ais_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AIS_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              seq_start,
    input  wire logic              sample_done,
    input  wire logic [15:0]       pin_level,
    output logic      [3:0]        pos_channel,
    output logic                   neg_is_input_one,
    output logic                   pos_to_analog_ground,
    output logic      [15:0]       port_read_data,
    output logic      [15:0]       digital_read_enable,
    output logic      [15:0]       conv_timing
);

    ais_state_s st_r;
    ais_state_s st_nxt;

    logic [3:0]  grp;
    logic [1:0]  kind;
    logic        addr_ok;
    logic        wr_take;
    logic [31:0] rd_word;
    logic [3:0]  pos_a;
    logic [3:0]  cur_pos;
    logic        cur_neg;

    assign grp     = paddr[7:4];
    assign kind    = paddr[3:2];
    assign addr_ok = (paddr[AIS_AW-1:8] == '0) && (paddr[1:0] == 2'h0)
                     && ((grp < AIS_GRP_STATUS)
                         || (grp == AIS_GRP_STATUS && kind == AIS_KIND_BASE));
    // Zero-wait slave: pready is raised during setup, so access ends at once
    assign wr_take = psel && penable && st_r.pready && pwrite && addr_ok;

    // Reserved bits are masked off on every path, aliases included
    function automatic logic [31:0] alias_apply(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [1:0]  k,
        input logic [31:0] msk
    );
        logic [31:0] sel;
        sel = wd & msk;
        case (k)
            AIS_KIND_BASE: alias_apply = sel;
            AIS_KIND_CLR:  alias_apply = old & ~sel;
            AIS_KIND_SET:  alias_apply = old | sel;
            AIS_KIND_INV:  alias_apply = old ^ sel;
            default:       alias_apply = old;
        endcase
    endfunction

    // Lowest selected channel strictly above cur, wrapping to the lowest
    function automatic logic [3:0] next_scan(
        input logic [15:0] msk,
        input logic [3:0]  cur,
        input logic        from_start
    );
        logic [3:0] res;
        logic       hit;
        res = cur;
        hit = 1'b0;
        for (int i = AIS_CH_N - 1; i >= 0; i--)
        begin
            if (msk[i] && (from_start || i > int'(cur)))
            begin
                res = i[3:0];
                hit = 1'b1;
            end
        end
        if (!hit)
        begin
            for (int i = AIS_CH_N - 1; i >= 0; i--)
            begin
                if (msk[i])
                begin
                    res = i[3:0];
                end
            end
        end
        next_scan = res;
    endfunction

    always_comb
    begin
        rd_word = 32'h00000000;
        if (kind == AIS_KIND_BASE)
        begin
            case (grp)
                AIS_GRP_TIMING: rd_word = {16'h0000, st_r.timing};
                AIS_GRP_CTRL:   rd_word = ({31'h0, st_r.scan_en} << AIS_CTRL_SCAN)
                                          | ({31'h0, st_r.alternate_sampling_enable_en} << AIS_CTRL_ALTERNATE_SAMPLING_ENABLE);
                AIS_GRP_CHS:    rd_word = st_r.chs;
                AIS_GRP_PIN_MODE_BITS:   rd_word = {16'h0000, st_r.pin_mode_bits};
                AIS_GRP_SCAN_INCLUDE_BITS:   rd_word = {16'h0000, st_r.scan_include_bits};
                AIS_GRP_STATUS: rd_word = {24'h000000, st_r.seq == AIS_SEQ_RUN,
                                           st_r.use_b, st_r.pos_gnd, st_r.neg_an1,
                                           st_r.pos_ch};
                default:        rd_word = 32'h00000000;
            endcase
        end
    end

    // Current mux choice from the setting in use
    always_comb
    begin
        pos_a = st_r.scan_en ? st_r.scan_ch
                             : st_r.chs[AIS_CHS_POS_A +: 4];
        if (st_r.use_b)
        begin
            cur_pos = st_r.chs[AIS_CHS_POS_B +: 4];
            cur_neg = st_r.chs[AIS_CHS_NEG_B];
        end
        else
        begin
            cur_pos = pos_a;
            cur_neg = st_r.chs[AIS_CHS_NEG_A];
        end
    end

    always_comb
    begin
        logic [31:0] tmp;
        tmp    = 32'h00000000;
        st_nxt = st_r;

        // APB: answer prepared in the setup cycle
        st_nxt.pready  = psel && !penable;
        st_nxt.pslverr = psel && !penable && !addr_ok;
        if (psel && !penable)
        begin
            st_nxt.prdata = pwrite ? 32'h00000000 : rd_word;
        end
        if (wr_take)
        begin
            case (grp)
                AIS_GRP_TIMING:
                begin
                    tmp = alias_apply({16'h0000, st_r.timing}, pwdata, kind,
                                      AIS_TIMING_MASK);
                    st_nxt.timing = tmp[15:0];
                end
                AIS_GRP_CTRL:
                begin
                    tmp = alias_apply(({31'h0, st_r.scan_en} << AIS_CTRL_SCAN)
                                      | ({31'h0, st_r.alternate_sampling_enable_en} << AIS_CTRL_ALTERNATE_SAMPLING_ENABLE),
                                      pwdata, kind, AIS_CTRL_MASK);
                    st_nxt.scan_en = tmp[AIS_CTRL_SCAN];
                    st_nxt.alternate_sampling_enable_en = tmp[AIS_CTRL_ALTERNATE_SAMPLING_ENABLE];
                end
                AIS_GRP_CHS:
                begin
                    st_nxt.chs = alias_apply(st_r.chs, pwdata, kind, AIS_CHS_MASK);
                end
                AIS_GRP_PIN_MODE_BITS:
                begin
                    tmp = alias_apply({16'h0000, st_r.pin_mode_bits}, pwdata, kind,
                                      AIS_PIN_MASK);
                    st_nxt.pin_mode_bits = tmp[15:0];
                end
                AIS_GRP_SCAN_INCLUDE_BITS:
                begin
                    tmp = alias_apply({16'h0000, st_r.scan_include_bits}, pwdata, kind,
                                      AIS_PIN_MASK);
                    st_nxt.scan_include_bits = tmp[15:0];
                end
                default:
                begin
                    st_nxt.chs = st_r.chs;
                end
            endcase
        end

        // Sample sequencing; a new sequence wins over a finishing sample
        case (st_r.seq)
            AIS_SEQ_IDLE:
            begin
                st_nxt.use_b = 1'b0;
                if (seq_start)
                begin
                    st_nxt.seq     = AIS_SEQ_RUN;
                    st_nxt.scan_ch = next_scan(st_r.scan_include_bits, 4'h0, 1'b1);
                end
            end
            AIS_SEQ_RUN:
            begin
                if (seq_start)
                begin
                    st_nxt.use_b   = 1'b0;
                    st_nxt.scan_ch = next_scan(st_r.scan_include_bits, 4'h0, 1'b1);
                end
                else if (sample_done)
                begin
                    st_nxt.use_b = st_r.alternate_sampling_enable_en && !st_r.use_b;
                    if (st_r.scan_en && !st_r.use_b)
                    begin
                        // Empty mask leaves the channel where it is
                        st_nxt.scan_ch = next_scan(st_r.scan_include_bits, st_r.scan_ch, 1'b0);
                    end
                end
            end
            default:
            begin
                st_nxt.seq = AIS_SEQ_IDLE;
            end
        endcase

        // Outputs follow the state one cycle later, all from flops
        st_nxt.pos_ch  = cur_pos;
        st_nxt.neg_an1 = cur_neg;
        st_nxt.pos_gnd = st_r.pin_mode_bits[cur_pos];
        st_nxt.port_rd = (pin_level & st_r.pin_mode_bits) | ~st_r.pin_mode_bits;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata               = st_r.prdata;
    assign pready               = st_r.pready;
    assign pslverr              = st_r.pslverr;
    assign pos_channel          = st_r.pos_ch;
    assign neg_is_input_one     = st_r.neg_an1;
    assign pos_to_analog_ground = st_r.pos_gnd;
    assign port_read_data       = st_r.port_rd;
    assign digital_read_enable  = st_r.pin_mode_bits;
    assign conv_timing          = st_r.timing;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_alias_wr(logic [11:0] off, logic [1:0] k);
        wr_take && paddr == (off | {8'h00, k, 2'b00});
    endsequence

    sequence s_run_sample;
        st_r.seq == AIS_SEQ_RUN && sample_done && !seq_start;
    endsequence

    a_chs_clear: assert property (s_alias_wr(AIS_OFF_CHS, AIS_KIND_CLR) |=>
        st_r.chs == ($past(st_r.chs) & ~($past(pwdata) & AIS_CHS_MASK)))
        else $error("clear alias result wrong");

    a_pin_mode_bits_set: assert property (s_alias_wr(AIS_OFF_PIN_MODE_BITS, AIS_KIND_SET) |=>
        st_r.pin_mode_bits == ($past(st_r.pin_mode_bits) | $past(pwdata[15:0])))
        else $error("set alias result wrong");

    a_scan_include_bits_invert: assert property (s_alias_wr(AIS_OFF_SCAN_INCLUDE_BITS, AIS_KIND_INV) |=>
        st_r.scan_include_bits == ($past(st_r.scan_include_bits) ^ $past(pwdata[15:0])))
        else $error("invert alias result wrong");

    a_alias_zero_keep: assert property ((s_alias_wr(AIS_OFF_CHS, AIS_KIND_SET)
        && pwdata == 32'h00000000) |=> $stable(st_r.chs))
        else $error("zero alias write changed register");

    a_reserved_zero: assert property ((st_r.chs & ~AIS_CHS_MASK) == 32'h0
        && st_r.timing[14:13] == 2'h0)
        else $error("reserved bit set");

    a_alias_read_zero: assert property ((psel && !penable && !pwrite
        && kind != AIS_KIND_BASE) |=> prdata == 32'h0 && pready)
        else $error("alias read not answered with zero");

    a_pos_select: assert property (1'b1 |=> pos_channel == $past(cur_pos)
        && ($past(st_r.use_b) || $past(st_r.scan_en)
            || pos_channel == $past(st_r.chs[AIS_CHS_POS_A +: 4])))
        else $error("positive select wrong");

    a_neg_select: assert property (1'b1 |=> neg_is_input_one ==
        ($past(st_r.use_b) ? $past(st_r.chs[AIS_CHS_NEG_B])
                           : $past(st_r.chs[AIS_CHS_NEG_A])))
        else $error("negative select wrong");

    a_ground_tie: assert property (1'b1 |=>
        pos_to_analog_ground == $past(st_r.pin_mode_bits[cur_pos]))
        else $error("ground tie wrong");

    a_port_read: assert property (1'b1 |=>
        port_read_data == ($past(pin_level) | ~$past(st_r.pin_mode_bits)))
        else $error("digital port read wrong");

    a_seq_first_a: assert property (seq_start |=> !st_r.use_b)
        else $error("sequence did not start on first setting");

    a_alt_toggle: assert property ((s_run_sample and st_r.alternate_sampling_enable_en) |=>
        st_r.use_b != $past(st_r.use_b))
        else $error("alternation missed");

    a_scan_member: assert property ((seq_start && st_r.scan_include_bits != 16'h0) |=>
        st_r.scan_include_bits[st_r.scan_ch] && (st_r.scan_include_bits & ((16'h1 << st_r.scan_ch) - 16'h1)) == 16'h0)
        else $error("scan did not start at lowest selected input");

endmodule // ais_input_select

// File: ais_input_select_tb.sv
// Self-checking testbench for the converter input-select register bank
`timescale 1ns/100ps
module ais_input_select_tb import ais_pkg::*;;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic        e;
    } ais_note_s;

    logic              core_clk;
    logic              reset;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [AIS_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              seq_start;
    logic              sample_done;
    logic [15:0]       pin_level;
    logic [3:0]        pos_channel;
    logic              neg_is_input_one;
    logic              pos_to_analog_ground;
    logic [15:0]       port_read_data;
    logic [15:0]       digital_read_enable;
    logic [15:0]       conv_timing;
    int                err_count;
    int                n_checks;
    ais_note_s         notes[$];
    ais_note_s         nt;
    logic [31:0]       model [5];
    logic [31:0]       imask [5];
    logic [11:0]       offs  [5];
    logic [31:0]       pc;

    ais_input_select DUT (
        .core_clk             (core_clk),
        .reset                (reset),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .seq_start            (seq_start),
        .sample_done          (sample_done),
        .pin_level            (pin_level),
        .pos_channel          (pos_channel),
        .neg_is_input_one     (neg_is_input_one),
        .pos_to_analog_ground (pos_to_analog_ground),
        .port_read_data       (port_read_data),
        .digital_read_enable  (digital_read_enable),
        .conv_timing          (conv_timing)
    );

    always #10 core_clk = ~core_clk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One full APB transfer; the expected answer is noted before setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        notes.push_back('{w ? 32'h0 : d, m, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= w ? d : 32'h0;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            check("pready wait", 32'h0, 32'h1);
            close_out();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_op(input int g, input logic [1:0] k, input logic [31:0] d);
        case (k)
            AIS_KIND_BASE: model[g] = d & imask[g];
            AIS_KIND_CLR:  model[g] = model[g] & ~d;
            AIS_KIND_SET:  model[g] = model[g] | (d & imask[g]);
            default:       model[g] = model[g] ^ (d & imask[g]);
        endcase
        apb(1'b1, offs[g] + {8'h0, k, 2'b00}, d, 32'h0, 1'b0);
    endtask

    task automatic reg_rd(input int g);
        apb(1'b0, offs[g], model[g], 32'hffffffff, 1'b0);
    endtask

    // Outputs settle one edge after the edge that takes the pulse; the check waits two
    task automatic pulse(input logic st, input logic [3:0] ch, input logic neg);
        @(posedge core_clk);
        if (st)
            seq_start <= 1'b1;
        else
            sample_done <= 1'b1;
        @(posedge core_clk);
        seq_start   <= 1'b0;
        sample_done <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("pos_channel", {28'h0, pos_channel}, {28'h0, ch});
        check("neg_is_input_one", {31'h0, neg_is_input_one}, {31'h0, neg});
        check("pos_to_analog_ground", {31'h0, pos_to_analog_ground}, {31'h0, model[3][ch]});
    endtask

    // Monitor: every completed transfer consumes the oldest note
    always @(posedge core_clk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            if (notes.size() == 0)
                check("note queue", 32'h1, 32'h0);
            else
            begin
                nt = notes.pop_front();
                check("prdata", prdata & nt.m, nt.d);
                check("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
            end
        end
    end

    initial
    begin
        // Whole run is about 500 cycles; 20000 cycles is ample margin
        #400000;
        err_count++;
        close_out();
    end

    initial
    begin
        core_clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        seq_start = 1'b0;
        sample_done = 1'b0;
        pin_level = '0;
        err_count = 0;
        n_checks = 0;
        imask = '{AIS_TIMING_MASK, AIS_CTRL_MASK, AIS_CHS_MASK, AIS_PIN_MASK, AIS_PIN_MASK};
        offs = '{AIS_OFF_TIMING, AIS_OFF_CTRL, AIS_OFF_CHS, AIS_OFF_PIN_MODE_BITS, AIS_OFF_SCAN_INCLUDE_BITS};
        model = '{default: AIS_RST_VALUE};
        void'($urandom(32'hcc88));
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("port_read_data", {16'h0, port_read_data}, 32'h0000ffff);
        check("digital_read_enable", {16'h0, digital_read_enable}, 32'h0);
        for (int g = 0; g < 5; g++)
            reg_rd(g);
        // Base writes keep reserved bits zero; aliases get ones there on purpose
        for (int g = 0; g < 5; g++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                pc = $urandom;
                if (i == 0)
                    reg_op(g, AIS_KIND_BASE, pc & imask[g]);
                else
                    reg_op(g, 2'(i % 3 + 1), pc);
                apb(1'b0, offs[g] + 12'h004, 32'h0, 32'h0, 1'b0);
                reg_rd(g);
            end
        end
        repeat (2) @(posedge core_clk);
        #1;
        check("conv_timing", {16'h0, conv_timing}, model[0] & 32'h0000ffff);
        // Unmapped place: refused, nothing changes
        apb(1'b0, 12'h060, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 12'h060, 32'hffffffff, 32'h0, 1'b1);
        for (int g = 0; g < 5; g++)
            reg_rd(g);
        // Pin mode mask against pin levels
        for (int i = 0; i < 4; i++)
        begin
            reg_op(3, AIS_KIND_BASE, $urandom & AIS_PIN_MASK);
            @(posedge core_clk);
            pin_level <= 16'($urandom);
            repeat (3) @(posedge core_clk);
            #1;
            pc = model[3];
            check("port_read_data", {16'h0, port_read_data},
                  {16'h0, (pin_level & pc[15:0]) | ~pc[15:0]});
            check("digital_read_enable", {16'h0, digital_read_enable}, pc);
        end
        // Alternating settings: first, second, first, second, restart
        reg_op(3, AIS_KIND_BASE, 32'h00000200);
        reg_op(2, AIS_KIND_BASE, 32'h09850000);
        reg_op(1, AIS_KIND_BASE, 32'h00000001);
        pulse(1'b1, 4'h5, 1'b1);
        pulse(1'b0, 4'h9, 1'b0);
        pulse(1'b0, 4'h5, 1'b1);
        pulse(1'b0, 4'h9, 1'b0);
        pulse(1'b1, 4'h5, 1'b1);
        // Scan in ascending order over inputs 2, 5, 9, 11, then restart
        reg_op(4, AIS_KIND_BASE, 32'h00000a24);
        reg_op(1, AIS_KIND_BASE, 32'h00000400);
        pulse(1'b1, 4'h2, 1'b1);
        pulse(1'b0, 4'h5, 1'b1);
        pulse(1'b0, 4'h9, 1'b1);
        pulse(1'b0, 4'hb, 1'b1);
        pulse(1'b1, 4'h2, 1'b1);
        // Status: running, first setting, input 2 analog, negative on input one
        apb(1'b0, AIS_OFF_STATUS, 32'h00000092, 32'hffffffff, 1'b0);
        close_out();
    end
endmodule // ais_input_select_tb
